// ### rtl/mcr_misc_config.sv
// misc system configuration register bank: debug gate, tally, ref pin, rail level
//
// Our own choice: the strobed register port.

// Notes on behaviour
// [R1] enable set and gate pin high: debug port on, four-wire or two-wire by select
// [R2] enable clear: gate pin ignored, debug pins keep ordinary function
// [R3] gate pin low: setting enable does not start debug
// [R4] tally clears on power-on reset only, survives watchdog resets
// [R5] firmware writes the tally; hardware never counts it
// [R6] firmware clears watchdog status before bumping the tally
// [R7] reference-pin disable bit turns off the voltage reference, mux regardless
// [R8] rail bits and lock writable while unlocked, read-only once locked
// [R9] lock cannot be cleared by software, only by system reset
// [R10] rail-two bit: 1 means 1.8V, 0 means 3.3V
// [R11] firmware keeps the bank test bit at zero
// [R12] boot firmware loads rail bits from flash header, clears on failure
// [R13] pin-set field picks which debug pins switch over
// [R14] reserved bits read zero and ignore writes
module mcr_misc_config (
    // clock and resets
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic POR_N,
    // register port
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    // debug port
    input wire logic DEBUG_GATE,
    input wire logic DEBUG_TWO_WIRE_SEL,
    output logic DEBUG_ACTIVE,
    output logic DEBUG_TWO_WIRE,
    output logic [3:0] DEBUG_PIN_TAKE,
    // watchdog tally
    output logic [3:0] WATCHDOG_FIRE_TALLY,
    // cpu voltage reference pin
    output logic CPU_VOLTAGE_REFERENCE_EN,
    // io rail two
    input wire logic RAIL_TWO_STRAP_PIN,
    output logic [2:0] RAIL_VOLTAGE_BITS,
    output logic RAIL_TWO_LOW_VOLT,
    output logic RAIL_LOCKED
);

    // ------------------------------------------------------------
    // request carrier and decode
    // ------------------------------------------------------------
    mcr_pkg::mcr_req_s req;

    assign req.addr = REG_ADDR;
    assign req.wdata = REG_WDATA;
    assign req.wr = REG_WR;
    assign req.rd = REG_RD;

    logic sel_dbg;
    logic sel_tally;
    logic sel_ref;
    logic sel_rail;
    logic sel_strap;

    assign sel_dbg = (req.addr == mcr_pkg::OFS_DEBUG_PORT_CONTROL);
    assign sel_tally = (req.addr == mcr_pkg::OFS_WATCHDOG_EVENT_TALLY);
    assign sel_ref = (req.addr == mcr_pkg::OFS_REFERENCE_PIN_DISABLE);
    assign sel_rail = (req.addr == mcr_pkg::OFS_GPIO_BANK_RAIL_LEVEL);
    assign sel_strap = (req.addr == mcr_pkg::OFS_RAIL_STRAP_STATUS);

    // ------------------------------------------------------------
    // debug port control register
    // ------------------------------------------------------------
    logic dbg_en_r;
    mcr_pkg::mcr_pinset_e dbg_pinset_r;
    mcr_pkg::mcr_dbg_cfg_s dbg_cfg;

    // only the enable and pin-set fields are stored; the rest is dropped
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            dbg_en_r <= mcr_pkg::RST_DBG_EN;
        end else if (req.wr && sel_dbg) begin
            dbg_en_r <= req.wdata[mcr_pkg::DBG_EN_BIT]; // [R14]
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            dbg_pinset_r <= mcr_pkg::mcr_pinset_e'(mcr_pkg::RST_DBG_PINSET);
        end else if (req.wr && sel_dbg) begin
            dbg_pinset_r <= mcr_pkg::mcr_pinset_e'(
                req.wdata[mcr_pkg::DBG_PINSET_MSB:mcr_pkg::DBG_PINSET_LSB]); // [R13]
        end
    end

    assign dbg_cfg.enable = dbg_en_r;
    assign dbg_cfg.pinset = dbg_pinset_r;

    // ------------------------------------------------------------
    // debug gate
    // ------------------------------------------------------------
    mcr_debug_gate u_debug_gate (
        .clk(SYS_CLK),
        .rst_n(RESET_N),
        .cfg(dbg_cfg),
        .two_wire_sel(DEBUG_TWO_WIRE_SEL),
        .gate_pin(DEBUG_GATE),
        .active(DEBUG_ACTIVE),
        .two_wire(DEBUG_TWO_WIRE),
        .pin_take(DEBUG_PIN_TAKE)
    );

    // ------------------------------------------------------------
    // watchdog event tally
    // ------------------------------------------------------------
    logic [3:0] tally_r;

    // reset only by power-on, so a watchdog-driven system reset keeps it;
    // no increment path here, firmware owns the value
    always_ff @(posedge SYS_CLK or negedge POR_N) begin
        if (!POR_N) begin
            tally_r <= mcr_pkg::RST_TALLY; // [R4]
        end else if (req.wr && sel_tally) begin
            tally_r <= req.wdata[mcr_pkg::TALLY_MSB:mcr_pkg::TALLY_LSB]; // [R4] [R5]
        end
    end

    assign WATCHDOG_FIRE_TALLY = tally_r;

    // ------------------------------------------------------------
    // reference pin disable
    // ------------------------------------------------------------
    logic ref_off_r;

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ref_off_r <= mcr_pkg::RST_REF_OFF;
        end else if (req.wr && sel_ref) begin
            ref_off_r <= req.wdata[mcr_pkg::REF_OFF_BIT]; // [R14]
        end
    end

    // overrides the shared gpio mux, which never sees this path
    assign CPU_VOLTAGE_REFERENCE_EN = ~ref_off_r; // [R7]

    // ------------------------------------------------------------
    // gpio bank rail level and lock
    // ------------------------------------------------------------
    logic [2:0] rail_r;
    logic [2:0] rail_nxt;
    logic rail_lock_r;
    logic rail_lock_nxt;
    logic rail_wr_ok;

    assign rail_wr_ok = req.wr && sel_rail && !rail_lock_r; // [R8]

    always_comb begin
        rail_nxt = rail_r;
        if (rail_wr_ok) begin
            rail_nxt = req.wdata[mcr_pkg::RAIL_MSB:mcr_pkg::RAIL_LSB]; // [R8] [R10]
        end
    end

    // lock only ever rises; a written zero is dropped
    always_comb begin
        rail_lock_nxt = rail_lock_r;
        if (rail_wr_ok && req.wdata[mcr_pkg::RAIL_LOCK_BIT]) begin
            rail_lock_nxt = 1'b1; // [R8] [R9]
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rail_r <= mcr_pkg::RST_RAIL;
        end else begin
            rail_r <= rail_nxt; // [R8]
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rail_lock_r <= mcr_pkg::RST_RAIL_LOCK; // [R9]
        end else begin
            rail_lock_r <= rail_lock_nxt; // [R9]
        end
    end

    assign RAIL_VOLTAGE_BITS = rail_r;
    assign RAIL_TWO_LOW_VOLT = rail_r[mcr_pkg::RAIL_TWO_BIT]; // [R10]
    assign RAIL_LOCKED = rail_lock_r;

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    logic [31:0] rd_word;

    // unmapped offsets and reserved bits read as zero
    always_comb begin
        rd_word = mcr_pkg::RDATA_IDLE;
        if (sel_dbg) begin
            rd_word[mcr_pkg::DBG_EN_BIT] = dbg_en_r;
            rd_word[mcr_pkg::DBG_PINSET_MSB:mcr_pkg::DBG_PINSET_LSB] = dbg_pinset_r; // [R14]
        end else if (sel_tally) begin
            rd_word[mcr_pkg::TALLY_MSB:mcr_pkg::TALLY_LSB] = tally_r;
        end else if (sel_ref) begin
            rd_word[mcr_pkg::REF_OFF_BIT] = ref_off_r;
        end else if (sel_rail) begin
            rd_word[mcr_pkg::RAIL_MSB:mcr_pkg::RAIL_LSB] = rail_r;
            rd_word[mcr_pkg::RAIL_LOCK_BIT] = rail_lock_r; // [R14]
        end else if (sel_strap) begin
            // strap shown so boot code can pick the rail-two level
            rd_word[mcr_pkg::STRAP_BIT] = RAIL_TWO_STRAP_PIN; // [R10]
            rd_word[mcr_pkg::STRAP_LOCK_BIT] = rail_lock_r;
        end
    end

    // data valid only in the cycle after the read strobe
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            REG_RDATA <= mcr_pkg::RDATA_IDLE;
        end else if (req.rd) begin
            REG_RDATA <= rd_word;
        end else begin
            REG_RDATA <= mcr_pkg::RDATA_IDLE;
        end
    end

endmodule

// ### rtl/mcr_pkg.sv
// constants and carrier types for the misc config register bank
package mcr_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_DEBUG_PORT_CONTROL = 8'h20;
    localparam logic [7:0] OFS_WATCHDOG_EVENT_TALLY = 8'h28;
    localparam logic [7:0] OFS_REFERENCE_PIN_DISABLE = 8'h40;
    localparam logic [7:0] OFS_GPIO_BANK_RAIL_LEVEL = 8'h64;
    localparam logic [7:0] OFS_RAIL_STRAP_STATUS = 8'h68;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int DBG_EN_BIT = 0;
    localparam int DBG_PINSET_LSB = 1;
    localparam int DBG_PINSET_MSB = 2;
    localparam int TALLY_LSB = 0;
    localparam int TALLY_MSB = 3;
    localparam int REF_OFF_BIT = 0;
    localparam int RAIL_LSB = 0;
    localparam int RAIL_MSB = 2;
    localparam int RAIL_TWO_BIT = 1;
    localparam int RAIL_LOCK_BIT = 7;
    localparam int STRAP_BIT = 0;
    localparam int STRAP_LOCK_BIT = 1;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic RST_DBG_EN = 1'h0;
    localparam logic [1:0] RST_DBG_PINSET = 2'h0;
    localparam logic [3:0] RST_TALLY = 4'h0;
    localparam logic RST_REF_OFF = 1'h0;
    localparam logic [2:0] RST_RAIL = 3'h0;
    localparam logic RST_RAIL_LOCK = 1'h0;
    localparam logic [31:0] RDATA_IDLE = 32'h0000_0000;

    // ------------------------------------------------------------
    // pin-set selections for the debug port
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PINSET_ALL_FOUR = 2'h0,
        PINSET_CLK_MODE_OUT = 2'h1,
        PINSET_CLK_MODE = 2'h2,
        PINSET_RESERVED = 2'h3
    } mcr_pinset_e;

    // pin mask order: {clock, mode select, data in, data out}
    localparam logic [3:0] PINS_ALL_FOUR = 4'hF;
    localparam logic [3:0] PINS_CLK_MODE_OUT = 4'hD;
    localparam logic [3:0] PINS_CLK_MODE = 4'hC;
    localparam logic [3:0] PINS_NONE = 4'h0;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } mcr_req_s;

    typedef struct packed {
        logic enable;
        mcr_pinset_e pinset;
    } mcr_dbg_cfg_s;

endpackage

// ### rtl/mcr_debug_gate.sv
// debug port gating and pin-set selection
module mcr_debug_gate (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // configuration
    input mcr_pkg::mcr_dbg_cfg_s cfg,
    input wire logic two_wire_sel,
    // gate pin
    input wire logic gate_pin,
    // results
    output logic active,
    output logic two_wire,
    output logic [3:0] pin_take
);

    // ------------------------------------------------------------
    // pin-set decode
    // ------------------------------------------------------------
    function automatic logic [3:0] pins_of(input mcr_pkg::mcr_pinset_e sel);
        logic [3:0] m;
        m = mcr_pkg::PINS_NONE;
        unique case (sel)
            mcr_pkg::PINSET_ALL_FOUR: m = mcr_pkg::PINS_ALL_FOUR;
            mcr_pkg::PINSET_CLK_MODE_OUT: m = mcr_pkg::PINS_CLK_MODE_OUT;
            mcr_pkg::PINSET_CLK_MODE: m = mcr_pkg::PINS_CLK_MODE;
            // reserved code frees every pin rather than guess a mapping
            mcr_pkg::PINSET_RESERVED: m = mcr_pkg::PINS_NONE;
        endcase
        return m;
    endfunction

    logic active_nxt;

    // ------------------------------------------------------------
    // gating
    // ------------------------------------------------------------
    // low gate pin blocks debug even with enable set
    assign active_nxt = cfg.enable & gate_pin; // [R1] [R2] [R3]

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            active <= 1'b0;
        end else begin
            active <= active_nxt; // [R1] [R2] [R3]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            two_wire <= 1'b0;
        end else begin
            two_wire <= active_nxt & two_wire_sel; // [R1]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_take <= mcr_pkg::PINS_NONE;
        end else if (active_nxt) begin
            pin_take <= pins_of(cfg.pinset); // [R13]
        end else begin
            pin_take <= mcr_pkg::PINS_NONE; // [R2]
        end
    end

endmodule

// ### tb/mcr_misc_config_checker.sv
// port assertions for the misc config register bank
module mcr_misc_config_checker (
    // clock and resets
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic POR_N,
    // register port
    input wire logic [7:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [31:0] REG_RDATA,
    // debug port
    input wire logic DEBUG_GATE,
    input wire logic DEBUG_TWO_WIRE_SEL,
    input wire logic DEBUG_ACTIVE,
    input wire logic DEBUG_TWO_WIRE,
    input wire logic [3:0] DEBUG_PIN_TAKE,
    // tally, reference pin, rail
    input wire logic [3:0] WATCHDOG_FIRE_TALLY,
    input wire logic CPU_VOLTAGE_REFERENCE_EN,
    input wire logic RAIL_TWO_STRAP_PIN,
    input wire logic [2:0] RAIL_VOLTAGE_BITS,
    input wire logic RAIL_TWO_LOW_VOLT,
    input wire logic RAIL_LOCKED
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------
    // shadow of debug enable and pin set
    // ----------------
    logic en_r;
    logic [1:0] ps_r;
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            en_r <= 1'h0;
            ps_r <= 2'h0;
        end else if (REG_WR && REG_ADDR == 8'h20) begin
            en_r <= REG_WDATA[0];
            ps_r <= REG_WDATA[2:1];
        end
    end
    // ----------------
    // shadow of rail bits and lock
    // ----------------
    logic [2:0] rl_r;
    logic lk_r;
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rl_r <= 3'h0;
            lk_r <= 1'h0;
        end else if (REG_WR && REG_ADDR == 8'h64 && !lk_r) begin
            rl_r <= REG_WDATA[2:0];
            lk_r <= REG_WDATA[7];
        end
    end
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);
    property p_dbg_on;
        en_r && DEBUG_GATE |=> DEBUG_ACTIVE;
    endproperty
    a_dbg_on: assert property (p_dbg_on) else $error("debug not opened");
    property p_dbg_sel;
        DEBUG_TWO_WIRE == (DEBUG_ACTIVE && $past(DEBUG_TWO_WIRE_SEL));
    endproperty
    a_dbg_sel: assert property (p_dbg_sel) else $error("two-wire wrong");
    property p_dbg_off;
        !en_r |=> !DEBUG_ACTIVE && DEBUG_PIN_TAKE == 4'h0;
    endproperty
    a_dbg_off: assert property (p_dbg_off) else $error("debug on while disabled");
    property p_gate_low;
        !DEBUG_GATE |=> !DEBUG_ACTIVE && !DEBUG_TWO_WIRE;
    endproperty
    a_gate_low: assert property (p_gate_low) else $error("debug on with gate low");
    property p_pinset;
        en_r && DEBUG_GATE && ps_r == 2'h2 |=> DEBUG_PIN_TAKE == 4'hC;
    endproperty
    a_pinset: assert property (p_pinset) else $error("pin mask wrong");
    property p_tally_hold;
        @(posedge SYS_CLK) disable iff (!POR_N) !RESET_N |=> $stable(WATCHDOG_FIRE_TALLY);
    endproperty
    a_tally_hold: assert property (p_tally_hold) else $error("tally lost");
    property p_ref;
        REG_WR && REG_ADDR == 8'h40 |=> CPU_VOLTAGE_REFERENCE_EN != $past(REG_WDATA[0]);
    endproperty
    a_ref: assert property (p_ref) else $error("reference pin wrong");
    property p_locked;
        RAIL_LOCKED |=> RAIL_LOCKED && $stable(RAIL_VOLTAGE_BITS);
    endproperty
    a_locked: assert property (p_locked) else $error("locked rail changed");
    property p_low_volt;
        RAIL_TWO_LOW_VOLT == rl_r[1] && RAIL_VOLTAGE_BITS == rl_r && RAIL_LOCKED == lk_r;
    endproperty
    a_low_volt: assert property (p_low_volt) else $error("rail two level wrong");
    property p_unmapped;
        REG_RD && REG_ADDR == 8'h10 |=> REG_RDATA == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule
bind mcr_misc_config mcr_misc_config_checker u_chk (.*);

// ### tb/tb_mcr_misc_config.sv
// self-checking bench for the misc config register bank
module tb_mcr_misc_config;
    timeunit 1ns;
    timeprecision 100ps;
    logic SYS_CLK = 1'h0;
    logic RESET_N = 1'h0;
    logic POR_N = 1'h0;
    logic [7:0] REG_ADDR = 8'h00;
    logic [31:0] REG_WDATA = 32'h0;
    logic REG_WR = 1'h0;
    logic REG_RD = 1'h0;
    logic [31:0] REG_RDATA;
    logic DEBUG_GATE = 1'h0;
    logic DEBUG_TWO_WIRE_SEL = 1'h0;
    logic DEBUG_ACTIVE;
    logic DEBUG_TWO_WIRE;
    logic [3:0] DEBUG_PIN_TAKE;
    logic [3:0] WATCHDOG_FIRE_TALLY;
    logic CPU_VOLTAGE_REFERENCE_EN;
    logic RAIL_TWO_STRAP_PIN = 1'h0;
    logic [2:0] RAIL_VOLTAGE_BITS;
    logic RAIL_TWO_LOW_VOLT;
    logic RAIL_LOCKED;
    int num_errors = 0;
    int tests_run = 0;
    mcr_misc_config dut (.*);
    always #2 SYS_CLK = ~SYS_CLK;
    // ----------------
    // shared tasks
    // ----------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge SYS_CLK);
        REG_WR <= 1'h1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge SYS_CLK);
        REG_WR <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge SYS_CLK);
        REG_RD <= 1'h1;
        REG_ADDR <= a;
        @(posedge SYS_CLK);
        REG_RD <= 1'h0;
        #1 chk(REG_RDATA, exp);
    endtask
    // debug outputs follow one cycle after their inputs
    task automatic settle;
        repeat (2) @(posedge SYS_CLK);
        #1;
    endtask
    // por low too means power-on; alone it is a watchdog reset
    task automatic do_rst(input logic por);
        @(posedge SYS_CLK);
        RESET_N <= 1'h0;
        POR_N <= ~por;
        repeat (6) @(posedge SYS_CLK);
        RESET_N <= 1'h1;
        POR_N <= 1'h1;
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ----------------
    // scenarios
    // ----------------
    task automatic t_reset;
        logic [7:0] ofs[4] = '{8'h20, 8'h28, 8'h40, 8'h64};
        foreach (ofs[i]) rd(ofs[i], 32'h0);
        $display("t_reset done");
    endtask
    task automatic t_debug;
        logic [3:0] mask[4] = '{4'hF, 4'hD, 4'hC, 4'h0};
        wr(8'h20, 32'h1);
        settle;
        chk(DEBUG_ACTIVE, 1'h0);
        for (int i = 0; i < 4; i++) begin
            wr(8'h20, {29'h0, i[1:0], 1'h1});
            DEBUG_GATE <= 1'h1;
            DEBUG_TWO_WIRE_SEL <= i[0];
            settle;
            chk(DEBUG_ACTIVE, 1'h1);
            chk(DEBUG_TWO_WIRE, i[0]);
            chk(DEBUG_PIN_TAKE, mask[i]);
        end
        wr(8'h20, 32'h0);
        settle;
        chk({DEBUG_ACTIVE, DEBUG_PIN_TAKE}, 5'h00);
        wr(8'h20, 32'hFFFF_FFFF);
        rd(8'h20, 32'h7);
        @(posedge SYS_CLK);
        DEBUG_GATE <= 1'h0;
        settle;
        chk({DEBUG_ACTIVE, DEBUG_TWO_WIRE}, 2'h0);
        wr(8'h20, 32'h0);
        $display("t_debug done");
    endtask
    task automatic t_tally;
        wr(8'h28, 32'hFFFF_FFF5);
        rd(8'h28, 32'h5);
        do_rst(1'h0);
        #1 chk(WATCHDOG_FIRE_TALLY, 4'h5);
        rd(8'h28, 32'h5);
        // watchdog status is cleared elsewhere first, then firmware bumps the tally
        wr(8'h28, 32'h6);
        settle;
        chk(WATCHDOG_FIRE_TALLY, 4'h6);
        do_rst(1'h1);
        #1 chk(WATCHDOG_FIRE_TALLY, 4'h0);
        $display("t_tally done");
    endtask
    task automatic t_ref;
        chk(CPU_VOLTAGE_REFERENCE_EN, 1'h1);
        wr(8'h40, 32'hFFFF_FFFF);
        #1 chk(CPU_VOLTAGE_REFERENCE_EN, 1'h0);
        rd(8'h40, 32'h1);
        wr(8'h40, 32'h0);
        #1 chk(CPU_VOLTAGE_REFERENCE_EN, 1'h1);
        $display("t_ref done");
    endtask
    task automatic t_rail;
        @(posedge SYS_CLK);
        RAIL_TWO_STRAP_PIN <= 1'h1;
        rd(8'h68, 32'h1);
        // strap high means a 1.8V rail; test bit always written zero
        wr(8'h64, 32'h2);
        rd(8'h64, 32'h2);
        chk(RAIL_TWO_LOW_VOLT, 1'h1);
        wr(8'h64, 32'hFFFF_FF84);
        rd(8'h64, 32'h84);
        wr(8'h64, 32'h2);
        rd(8'h64, 32'h84);
        chk({RAIL_LOCKED, RAIL_VOLTAGE_BITS, RAIL_TWO_LOW_VOLT}, 5'h18);
        rd(8'h68, 32'h3);
        wr(8'h10, 32'hFFFF_FFFF);
        rd(8'h10, 32'h0);
        do_rst(1'h0);
        #1 chk(RAIL_LOCKED, 1'h0);
        wr(8'h64, 32'h6);
        rd(8'h64, 32'h6);
        // flash load failed: boot code clears every rail bit
        wr(8'h64, 32'h0);
        rd(8'h64, 32'h0);
        $display("t_rail done");
    endtask
    // hang guard
    initial begin
        #40000;
        num_errors++;
        summarize();
    end
    initial begin
        do_rst(1'h1);
        t_reset();
        t_debug();
        t_tally();
        t_ref();
        t_rail();
        summarize();
    end
endmodule
